/* design/drive_input_function_logic.sv */
`timescale 1ns/1ps
// How it works
// - failed loopback test raises alarm and fault output
// - brake input closed while running starts braking
// - braking holds until drive fully stopped
// - second jog without three-wire flags conflict
// - second jog ramps to jog reference
// - open enable blocks run, shows message
// - run held before enable needs recycling
// - enable opening while running stops drive
// - serial select closed picks serial port
// - inverted select closed picks terminals
// - source change applied only while stopped
// - hand closed picks keypad speed source
// - auto open picks keypad speed source
// - hand/auto leave run source alone
// - auto and hand together flag conflict
// - open bypass blocks run, shows message while run is given
// - bypass needs no run command cycling
// - bypass opening while running stops drive
module drive_input_function_logic
  import drive_input_pkg::*;
#(
  parameter int N = NUM_INPUTS
) (
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  input  wire logic [N-1:0]          contact_closed,
  input  wire logic [N*FUNC_W-1:0]   input_function_select,
  input  wire logic [SRC_W-1:0]      freq_ref_source_select,
  input  wire logic [SRC_W-1:0]      run_cmd_source_select,
  input  wire logic [STOP_W-1:0]     stop_method_select,
  input  wire logic                  three_wire_mode,
  input  wire logic                  three_wire_reverse,
  input  wire logic                  terminal_run,
  input  wire logic                  serial_run,
  input  wire logic                  drive_running,
  input  wire logic                  drive_stopped,
  input  wire logic                  self_test_start,
  input  wire logic                  loopback_done,
  input  wire logic                  loopback_ok,
  input  wire logic [FREQ_W-1:0]     jog_freq_reference,
  output logic                       run_permit,
  output logic                       stop_request,
  output logic [STOP_W-1:0]          stop_method,
  output logic                       high_slip_brake,
  output logic                       jog_active,
  output logic                       jog_reverse,
  output logic [FREQ_W-1:0]          jog_target,
  output logic                       run_from_serial,
  output logic [1:0]                 speed_ref_select,
  output logic                       not_enabled_message,
  output logic                       config_conflict_fault,
  output logic                       comm_test_pass,
  output logic                       comm_error_alarm,
  output logic                       fault_output
);

  if (N < 1 || N > 16) begin : g_chk
    $error("input count out of range");
  end

  func_decode_if #(.N(N)) dec_bus ();
  assign dec_bus.contact = contact_closed;

  func_decoder #(.N(N)) u_dec (
    .input_function_select (input_function_select),
    .dec                   (dec_bus)
  );

  logic       hsb_reg, hsb_next;
  logic       serial_reg;
  logic       run_seen_reg;
  logic       blocked_reg, blocked_next;
  logic       conflict_reg;
  self_test_t test_reg, test_next;
  logic [FREQ_W-1:0] jog_reg;
  logic       jog_rev_reg;
  logic       jog_on_reg;

  // decoded run command from the currently latched source
  wire logic run_cmd     = serial_reg ? serial_run : terminal_run;
  wire logic enable_ok   = !dec_bus.enable_used || dec_bus.enable_in;
  wire logic bypass_ok   = !dec_bus.bypass_used || dec_bus.bypass_in;
  wire logic run_rise    = run_cmd && !run_seen_reg;
  wire logic conflict_now = (dec_bus.second_jog_input_used && !three_wire_mode)
                          || (dec_bus.auto_used && dec_bus.hand_used);
  wire logic hsb_start   = dec_bus.high_slip_in && drive_running;

  // a gate only counts when its code is assigned and no contact closes it
  function automatic logic gate_open(input logic used, input logic closed);
    gate_open = used && !closed;
  endfunction
  wire logic enable_open = gate_open(dec_bus.enable_used, dec_bus.enable_in);
  wire logic bypass_open = gate_open(dec_bus.bypass_used, dec_bus.bypass_in);

  // enable gate: a run present while enable is open stays blocked until it drops
  always_comb begin
    blocked_next = blocked_reg;
    if (!run_cmd || !dec_bus.enable_used) begin
      blocked_next = 1'b0;
    end else if (!enable_ok && dec_bus.enable_used) begin
      blocked_next = 1'b1;
    end
  end

  assign hsb_next = hsb_reg ? !drive_stopped : hsb_start;

  always_comb begin
    test_next = test_reg;
    unique case (test_reg)
      SELF_IDLE: begin
        if (self_test_start && dec_bus.comm_test_used) test_next = SELF_RUN;
      end
      SELF_RUN: begin
        if (loopback_done) test_next = loopback_ok ? SELF_PASS : SELF_FAIL;
      end
      SELF_PASS: begin
        test_next = SELF_PASS;
      end
      SELF_FAIL: begin
        test_next = SELF_FAIL;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hsb_reg      <= 1'b0;
      blocked_reg  <= 1'b0;
      run_seen_reg <= 1'b0;
      conflict_reg <= 1'b0;
      test_reg     <= SELF_IDLE;
    end else begin
      hsb_reg      <= hsb_next;
      blocked_reg  <= blocked_next;
      run_seen_reg <= run_cmd;
      conflict_reg <= conflict_now;
      test_reg     <= test_next;
    end
  end

  // source swap waits for standstill so a running drive never changes masters
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_reg <= 1'b0;
    end else if (drive_stopped) begin
      serial_reg <= dec_bus.serial_sel_used && dec_bus.serial_sel_in;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      jog_on_reg  <= 1'b0;
      jog_rev_reg <= 1'b0;
      jog_reg     <= '0;
    end else begin
      jog_on_reg  <= dec_bus.second_jog_input_in && three_wire_mode && !conflict_now;
      jog_rev_reg <= three_wire_reverse;
      jog_reg     <= jog_freq_reference;
    end
  end

  // run needs both gates; bypass only looks at levels, so no cycling is needed
  wire logic enable_path = enable_ok && !blocked_next;
  assign run_permit   = run_cmd && enable_path && bypass_ok
                        && !conflict_reg && !hsb_reg;
  assign stop_request = drive_running && ((dec_bus.enable_used && !dec_bus.enable_in)
                        || (dec_bus.bypass_used && !dec_bus.bypass_in));
  assign stop_method  = stop_method_select;
  assign high_slip_brake = hsb_reg;
  assign jog_active   = jog_on_reg;
  assign jog_reverse  = jog_rev_reg;
  assign jog_target   = jog_reg;
  assign run_from_serial = serial_reg;

  // hand/auto only steer the speed reference
  wire logic keypad_sel = (dec_bus.hand_used && dec_bus.hand_in)
                        || (dec_bus.auto_used && !dec_bus.auto_in);
  assign speed_ref_select = jog_on_reg ? REF_JOG
                          : keypad_sel ? REF_KEYPAD
                          : serial_reg ? REF_SERIAL : REF_CONFIGURED;

  // the message covers the normal gate regardless of run, bypass only with run
  assign not_enabled_message = (dec_bus.enable_used && !dec_bus.enable_in)
                             || (dec_bus.bypass_used && !dec_bus.bypass_in && run_cmd);
  assign config_conflict_fault = conflict_reg;
  assign comm_test_pass   = (test_reg == SELF_PASS);
  assign comm_error_alarm = (test_reg == SELF_FAIL);
  assign fault_output     = (test_reg == SELF_FAIL) || conflict_reg;

  a_hsb_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    hsb_reg && !drive_stopped |=> hsb_reg) else $error("braking left before stop");
  a_hsb_start: assert property (@(posedge ref_clk) disable iff (!arst_n)
    hsb_start |=> hsb_reg) else $error("braking not started");
  a_conflict_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
    conflict_now |=> config_conflict_fault) else $error("conflict not flagged");
  a_enable_block: assert property (@(posedge ref_clk) disable iff (!arst_n)
    dec_bus.enable_used && !dec_bus.enable_in |-> !run_permit && not_enabled_message)
    else $error("run while enable open");
  sequence s_run_before_en;
    run_cmd && dec_bus.enable_used && !dec_bus.enable_in ##1 run_cmd && enable_ok;
  endsequence
  a_run_cycle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_run_before_en |-> !run_permit) else $error("run without cycling");
  a_bypass_stop: assert property (@(posedge ref_clk) disable iff (!arst_n)
    drive_running && dec_bus.bypass_used && !dec_bus.bypass_in |-> stop_request)
    else $error("no stop on bypass open");
  a_src_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !drive_stopped |=> $stable(run_from_serial)) else $error("source changed while running");
  a_self_fail: assert property (@(posedge ref_clk) disable iff (!arst_n)
    test_reg == SELF_RUN && loopback_done && !loopback_ok |=> comm_error_alarm && fault_output)
    else $error("self test failure not reported");
  a_keypad_hand: assert property (@(posedge ref_clk) disable iff (!arst_n)
    dec_bus.hand_used && dec_bus.hand_in && !jog_on_reg |-> speed_ref_select == REF_KEYPAD)
    else $error("hand mode not on keypad");

  a_self_pass: assert property (@(posedge ref_clk) disable iff (!arst_n)
    test_reg == SELF_RUN && loopback_done && loopback_ok
    |=> comm_test_pass && !comm_error_alarm
  ) else $error("self test pass not shown");

  a_result_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    comm_test_pass || comm_error_alarm
    |=> $stable(test_reg)
  ) else $error("self test result lost");

  a_alarm_fault: assert property (@(posedge ref_clk) disable iff (!arst_n)
    comm_error_alarm
    |-> fault_output
  ) else $error("alarm without fault output");

  a_hsb_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !high_slip_brake && !hsb_start
    |=> !high_slip_brake
  ) else $error("braking without request");

  a_hsb_release: assert property (@(posedge ref_clk) disable iff (!arst_n)
    high_slip_brake && drive_stopped
    |=> !high_slip_brake
  ) else $error("braking kept after stop");

  a_hsb_gate: assert property (@(posedge ref_clk) disable iff (!arst_n)
    high_slip_brake
    |-> !run_permit
  ) else $error("run during braking");

  a_jog_conflict: assert property (@(posedge ref_clk) disable iff (!arst_n)
    dec_bus.second_jog_input_used && !three_wire_mode
    |=> config_conflict_fault && fault_output
  ) else $error("jog without three wire not flagged");

  a_jog_start: assert property (@(posedge ref_clk) disable iff (!arst_n)
    dec_bus.second_jog_input_in && three_wire_mode && !conflict_now
    |=> jog_active && speed_ref_select == REF_JOG
  ) else $error("jog not started");

  a_jog_stop: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !dec_bus.second_jog_input_in
    |=> !jog_active
  ) else $error("jog kept after release");

  a_jog_dir: assert property (@(posedge ref_clk) disable iff (!arst_n)
    1'b1
    |=> jog_reverse == $past(three_wire_reverse)
  ) else $error("jog direction wrong");

  a_jog_target: assert property (@(posedge ref_clk) disable iff (!arst_n)
    1'b1
    |=> jog_target == $past(jog_freq_reference)
  ) else $error("jog target wrong");

  a_enable_stop: assert property (@(posedge ref_clk) disable iff (!arst_n)
    drive_running && enable_open
    |-> stop_request && stop_method == stop_method_select
  ) else $error("no stop on enable open");

  a_run_rise: assert property (@(posedge ref_clk) disable iff (!arst_n)
    run_rise && enable_ok && bypass_ok && !conflict_reg && !hsb_reg
    |-> run_permit
  ) else $error("fresh run refused");

  a_serial_pick: assert property (@(posedge ref_clk) disable iff (!arst_n)
    drive_stopped && dec_bus.serial_sel_used && dec_bus.serial_sel_in
    |=> run_from_serial
  ) else $error("serial source not taken");

  a_terminal_pick: assert property (@(posedge ref_clk) disable iff (!arst_n)
    drive_stopped && !(dec_bus.serial_sel_used && dec_bus.serial_sel_in)
    |=> !run_from_serial
  ) else $error("terminal source not taken");

  a_serial_ref: assert property (@(posedge ref_clk) disable iff (!arst_n)
    run_from_serial && !jog_active && !keypad_sel
    |-> speed_ref_select == REF_SERIAL
  ) else $error("serial speed source not used");

  a_keypad_auto: assert property (@(posedge ref_clk) disable iff (!arst_n)
    dec_bus.auto_used && !dec_bus.auto_in && !jog_active
    |-> speed_ref_select == REF_KEYPAD
  ) else $error("auto open not on keypad");

  a_auto_closed: assert property (@(posedge ref_clk) disable iff (!arst_n)
    dec_bus.auto_used && dec_bus.auto_in && !dec_bus.hand_used && !jog_active
    |-> speed_ref_select != REF_KEYPAD
  ) else $error("auto closed still on keypad");

  a_hand_open: assert property (@(posedge ref_clk) disable iff (!arst_n)
    dec_bus.hand_used && !dec_bus.hand_in && !dec_bus.auto_used && !jog_active
    |-> speed_ref_select != REF_KEYPAD
  ) else $error("hand open still on keypad");

  a_both_modes: assert property (@(posedge ref_clk) disable iff (!arst_n)
    dec_bus.auto_used && dec_bus.hand_used
    |=> config_conflict_fault && fault_output
  ) else $error("both modes not flagged");

  a_conflict_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !conflict_now
    |=> !config_conflict_fault
  ) else $error("conflict kept after fix");

  a_conflict_gate: assert property (@(posedge ref_clk) disable iff (!arst_n)
    config_conflict_fault
    |-> !run_permit && fault_output
  ) else $error("run during conflict");

  a_bypass_block: assert property (@(posedge ref_clk) disable iff (!arst_n)
    bypass_open
    |-> !run_permit
  ) else $error("run while bypass open");

  a_bypass_msg: assert property (@(posedge ref_clk) disable iff (!arst_n)
    bypass_open && run_cmd
    |-> not_enabled_message
  ) else $error("bypass message missing");

  sequence s_run_before_byp;
    run_cmd && bypass_open ##1 run_cmd && dec_bus.bypass_in;
  endsequence

  a_bypass_late: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_run_before_byp ##0 (!dec_bus.enable_used && !conflict_reg && !hsb_reg)
    |-> run_permit
  ) else $error("bypass needed run cycling");

  a_message_gate: assert property (@(posedge ref_clk) disable iff (!arst_n)
    not_enabled_message
    |-> !run_permit
  ) else $error("run allowed while message shown");
endmodule

/* design/drive_input_pkg.sv */
package drive_input_pkg;
  localparam int NUM_INPUTS = 7;
  localparam int FUNC_W     = 8;
  localparam int SRC_W      = 4;
  localparam int STOP_W     = 2;
  localparam int FREQ_W     = 16;
  // input function codes
  localparam logic [7:0] FN_HIGH_SLIP    = 8'h68;
  localparam logic [7:0] FN_SECOND_JOG_INPUT         = 8'h69;
  localparam logic [7:0] FN_DRIVE_ENABLE = 8'h6A;
  localparam logic [7:0] FN_SERIAL_SEL   = 8'h6B;
  localparam logic [7:0] FN_SERIAL_SEL_N = 8'h6C;
  localparam logic [7:0] FN_AUTO_MODE    = 8'h6D;
  localparam logic [7:0] FN_HAND_MODE    = 8'h6E;
  localparam logic [7:0] FN_BYPASS_EN    = 8'h70;
  localparam logic [7:0] FN_COMM_TEST    = 8'h67;
  localparam logic [3:0] SRC_TERMINALS   = 4'h1;
  // speed reference selection codes
  localparam logic [1:0] REF_CONFIGURED  = 2'h0;
  localparam logic [1:0] REF_KEYPAD      = 2'h1;
  localparam logic [1:0] REF_SERIAL      = 2'h2;
  localparam logic [1:0] REF_JOG         = 2'h3;
  typedef enum logic [1:0] {SELF_IDLE, SELF_RUN, SELF_PASS, SELF_FAIL} self_test_t;
endpackage

/* design/func_decode_if.sv */
`timescale 1ns/1ps
interface func_decode_if #(parameter int N = drive_input_pkg::NUM_INPUTS);
  logic [N-1:0] contact;
  logic         high_slip_in;
  logic         high_slip_used;
  logic         second_jog_input_in;
  logic         second_jog_input_used;
  logic         enable_in;
  logic         enable_used;
  logic         serial_sel_in;
  logic         serial_sel_used;
  logic         auto_in;
  logic         auto_used;
  logic         hand_in;
  logic         hand_used;
  logic         bypass_in;
  logic         bypass_used;
  logic         comm_test_used;
  modport decoder (input contact, output high_slip_in, high_slip_used, second_jog_input_in, second_jog_input_used,
                   enable_in, enable_used, serial_sel_in, serial_sel_used, auto_in, auto_used,
                   hand_in, hand_used, bypass_in, bypass_used, comm_test_used);
  modport user    (output contact, input high_slip_in, high_slip_used, second_jog_input_in, second_jog_input_used,
                   enable_in, enable_used, serial_sel_in, serial_sel_used, auto_in, auto_used,
                   hand_in, hand_used, bypass_in, bypass_used, comm_test_used);
endinterface

/* design/func_decoder.sv */
`timescale 1ns/1ps
module func_decoder
  import drive_input_pkg::*;
#(
  parameter int N = NUM_INPUTS
) (
  input  wire logic [N*FUNC_W-1:0] input_function_select,
  func_decode_if.decoder           dec
);
  logic [N-1:0] m_hsb, m_jog, m_en, m_ser, m_sern, m_auto, m_hand, m_byp, m_test;

  function automatic logic is_code(input logic [FUNC_W-1:0] v, input logic [FUNC_W-1:0] c);
    is_code = (v == c);
  endfunction

  // one comparator bank per terminal
  for (genvar i = 0; i < N; i++) begin : g_in
    wire logic [FUNC_W-1:0] f = input_function_select[i*FUNC_W +: FUNC_W];
    assign m_hsb[i]  = is_code(f, FN_HIGH_SLIP);
    assign m_jog[i]  = is_code(f, FN_SECOND_JOG_INPUT);
    assign m_en[i]   = is_code(f, FN_DRIVE_ENABLE);
    assign m_ser[i]  = is_code(f, FN_SERIAL_SEL);
    assign m_sern[i] = is_code(f, FN_SERIAL_SEL_N);
    assign m_auto[i] = is_code(f, FN_AUTO_MODE);
    assign m_hand[i] = is_code(f, FN_HAND_MODE);
    assign m_byp[i]  = is_code(f, FN_BYPASS_EN);
    assign m_test[i] = is_code(f, FN_COMM_TEST);
  end

  // several terminals on one function behave as a wired or of their contacts; inverted serial select terminals or their open contacts
  assign dec.high_slip_used  = |m_hsb;
  assign dec.high_slip_in    = |(m_hsb & dec.contact);
  assign dec.second_jog_input_used       = |m_jog;
  assign dec.second_jog_input_in         = |(m_jog & dec.contact);
  assign dec.enable_used     = |m_en;
  assign dec.enable_in       = |(m_en & dec.contact);
  assign dec.serial_sel_used = |(m_ser | m_sern);
  assign dec.serial_sel_in   = |(m_ser & dec.contact) | |(m_sern & ~dec.contact);
  assign dec.auto_used       = |m_auto;
  assign dec.auto_in         = |(m_auto & dec.contact);
  assign dec.hand_used       = |m_hand;
  assign dec.hand_in         = |(m_hand & dec.contact);
  assign dec.bypass_used     = |m_byp;
  assign dec.bypass_in       = |(m_byp & dec.contact);
  assign dec.comm_test_used  = |m_test;
endmodule

/* tb/loopback_model.sv */
`timescale 1ns/1ps
// serial port wired back on itself; ok is junk outside the done pulse
module loopback_model #(
  parameter int DELAY = 4
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic start,
  input  wire logic broken,
  output logic      done,
  output logic      ok
);
  int cnt;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt  <= 0;
      done <= 1'b0;
      ok   <= 1'b0;
    end else begin
      done <= (cnt == 1);
      ok   <= (cnt == 1) ? !broken : !ok;
      if (start)
        cnt <= DELAY;
      else if (cnt > 0)
        cnt <= cnt - 1;
    end
  end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import drive_input_pkg::*;
  typedef struct {int id; logic [15:0] v;} note_t;
  logic                    ref_clk = 1'b0;
  logic                    arst_n = 1'b0;
  logic [NUM_INPUTS-1:0]   contact = '0;
  logic [8*NUM_INPUTS-1:0] fsel;
  logic [STOP_W-1:0]       stop_sel = '0;
  logic [FREQ_W-1:0]       jog_ref = '0;
  logic                    tw = 1'b0, tw_rev = 1'b0, t_run = 1'b0, s_run = 1'b0;
  logic                    running = 1'b0, stopped = 1'b1, st_start = 1'b0, broken = 1'b0;
  logic                    lb_done, lb_ok, run_permit, stop_request, high_slip_brake;
  logic                    jog_active, jog_reverse, run_from_serial, not_enabled_message;
  logic                    config_conflict_fault, comm_test_pass, comm_error_alarm, fault_output;
  logic [STOP_W-1:0]       stop_method;
  logic [1:0]              speed_ref_select;
  logic [FREQ_W-1:0]       jog_target;
  logic [15:0]             seen [14];
  note_t                   q [$];
  note_t                   nt;
  int                      n_fail = 0, n_compared = 0, i, j;
  string                   nm [14] = '{"permit", "stop_req", "brake", "jog_on", "jog_rev",
    "jog_tgt", "from_serial", "ref_sel", "ne_msg", "conflict", "pass", "alarm", "fault", "stop_m"};
  always #2.5 ref_clk = ~ref_clk;
  always_comb seen = '{16'(run_permit), 16'(stop_request), 16'(high_slip_brake),
    16'(jog_active), 16'(jog_reverse), 16'(jog_target), 16'(run_from_serial),
    16'(speed_ref_select), 16'(not_enabled_message), 16'(config_conflict_fault),
    16'(comm_test_pass), 16'(comm_error_alarm), 16'(fault_output), 16'(stop_method)};
  drive_input_function_logic i_drive_input_function_logic (
    .ref_clk, .arst_n, .contact_closed(contact), .input_function_select(fsel),
    .freq_ref_source_select(SRC_TERMINALS),
    .run_cmd_source_select(SRC_TERMINALS),
    .stop_method_select(stop_sel), .three_wire_mode(tw), .three_wire_reverse(tw_rev),
    .terminal_run(t_run), .serial_run(s_run), .drive_running(running), .drive_stopped(stopped),
    .self_test_start(st_start), .loopback_done(lb_done), .loopback_ok(lb_ok),
    .jog_freq_reference(jog_ref), .run_permit, .stop_request, .stop_method, .high_slip_brake,
    .jog_active, .jog_reverse, .jog_target, .run_from_serial, .speed_ref_select,
    .not_enabled_message, .config_conflict_fault, .comm_test_pass, .comm_error_alarm,
    .fault_output);
  loopback_model i_loopback_model (
    .ref_clk, .arst_n, .start(st_start), .broken, .done(lb_done), .ok(lb_ok));
  task automatic go(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // two cycles cover the one-cycle register latency
  task automatic ck(int id, logic [15:0] v);
    go(2);
    q.push_back('{id, v});
    go(1);
  endtask
  task automatic chk(string name, logic [15:0] s, logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, e, s);
    end
  endtask
  task automatic clr();
    fsel = {NUM_INPUTS{8'h0F}};
  endtask
  task automatic rst();
    arst_n = 1'b0;
    go(20);
    arst_n = 1'b1;
  endtask
  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    #1;
    while (q.size() > 0) begin
      nt = q.pop_front();
      chk(nm[nt.id], seen[nt.id], nt.v);
    end
  end
  initial begin
    void'($urandom(11));
    clr();
    rst();
    fsel[7:0] = FN_SECOND_JOG_INPUT;
    ck(9, 1);
    ck(12, 1);
    tw = 1'b1;
    ck(9, 0);
    fsel[15:8] = FN_AUTO_MODE;
    fsel[23:16] = FN_HAND_MODE;
    ck(9, 1);
    fsel[23:16] = 8'h0F;
    ck(9, 0);
    $display("test conflict done");
    clr();
    fsel[7:0] = FN_SECOND_JOG_INPUT;
    jog_ref = FREQ_W'($urandom());
    tw_rev = 1'b1;
    contact[0] = 1'b1;
    ck(3, 1);
    ck(4, 1);
    ck(5, jog_ref);
    ck(7, REF_JOG);
    contact = '0;
    ck(3, 0);
    $display("test jog done");
    clr();
    fsel[15:8] = FN_DRIVE_ENABLE;
    t_run = 1'b1;
    ck(0, 0);
    ck(8, 1);
    contact[1] = 1'b1;
    ck(0, 0);
    ck(8, 0);
    t_run = 1'b0;
    ck(0, 0);
    t_run = 1'b1;
    ck(0, 1);
    running = 1'b1;
    stopped = 1'b0;
    stop_sel = STOP_W'($urandom());
    contact[1] = 1'b0;
    ck(1, 1);
    ck(13, stop_sel);
    ck(0, 0);
    $display("test enable done");
    t_run = 1'b0;
    running = 1'b0;
    stopped = 1'b1;
    clr();
    fsel[23:16] = FN_BYPASS_EN;
    go(2);
    t_run = 1'b1;
    ck(0, 0);
    ck(8, 1);
    contact[2] = 1'b1;
    ck(0, 1);
    running = 1'b1;
    stopped = 1'b0;
    contact[2] = 1'b0;
    ck(1, 1);
    t_run = 1'b0;
    $display("test bypass done");
    clr();
    fsel[31:24] = FN_HIGH_SLIP;
    contact[3] = 1'b1;
    ck(2, 1);
    contact[3] = 1'b0;
    ck(2, 1);
    running = 1'b0;
    stopped = 1'b1;
    ck(2, 0);
    contact[3] = 1'b1;
    ck(2, 0);
    contact = '0;
    $display("test braking done");
    clr();
    for (i = 0; i < 2; i++) begin
      fsel[39:32] = (i == 0) ? FN_SERIAL_SEL : FN_SERIAL_SEL_N;
      contact[4] = 1'b1;
      ck(6, 16'(i == 0));
      contact[4] = 1'b0;
      ck(6, 16'(i != 0));
    end
    running = 1'b1;
    stopped = 1'b0;
    contact[4] = 1'b1;
    ck(6, 1);
    running = 1'b0;
    stopped = 1'b1;
    ck(6, 0);
    ck(7, REF_CONFIGURED);
    $display("test source done");
    clr();
    fsel[39:32] = FN_SERIAL_SEL;
    contact = 7'h10;
    for (i = 0; i < 4; i++) begin
      fsel[47:40] = i[1] ? FN_AUTO_MODE : FN_HAND_MODE;
      contact[5] = i[0];
      ck(7, (i[0] ^ i[1]) ? REF_KEYPAD : REF_SERIAL);
      ck(6, 1);
    end
    $display("test hand auto done");
    clr();
    fsel[55:48] = FN_COMM_TEST;
    contact = 7'h40;
    for (i = 0; i < 2; i++) begin
      broken = i[0];
      rst();
      st_start = 1'b1;
      go(1);
      st_start = 1'b0;
      j = 0;
      while (j < 50 && comm_test_pass !== 1'b1 && comm_error_alarm !== 1'b1) begin
        go(1);
        j++;
      end
      if (j == 50) begin
        n_fail++;
        break;
      end
      ck(10, 16'(i == 0));
      ck(11, 16'(i != 0));
      ck(12, 16'(i != 0));
    end
    $display("test self test done");
    summarize();
  end
endmodule
